// >>> design/engine_fault_trip_monitor.sv
/*
 * Engine fault, alarm and shutdown monitor with AHB-Lite registers.
 * Assumes measured values arrive from logic on hclk; discrete pins
 * (run contact, alarm reset) are asynchronous and are synchronised here.
 */
// Local design decisions: the register addresses and register access over AHB-Lite.
`timescale 1ns/1ps
`default_nettype none
module engine_fault_trip_monitor
	import trip_monitor_pkg::*;
#(
	parameter int unsigned CYCLES_PER_SECOND = CYCLES_PER_SEC
) (
	input wire logic hclk,
	input wire logic hresetn,
	input wire logic clk_en,
	input wire logic hsel,
	input wire logic [31:0] haddr,
	input wire logic [1:0] htrans,
	input wire logic hwrite,
	input wire logic [2:0] hsize,
	input wire logic [31:0] hwdata,
	input wire logic hready,
	output logic hreadyout,
	output logic hresp,
	output logic [31:0] hrdata,
	input wire logic run_contact_pin,
	input wire logic alarm_reset_pin,
	input wire logic sensor1_lost,
	input wire logic sensor2_lost,
	input wire logic [15:0] analog_freq_hz,
	input wire logic [15:0] digital_freq_hz,
	input wire logic [11:0] load_loop_current,
	input wire logic [11:0] remote_loop_current,
	input wire logic [11:0] fuel_limit_loop_current,
	input wire logic serial_link_error,
	input wire logic [15:0] fuel_demand_pct,
	input wire logic [15:0] torsional_level,
	input wire logic [15:0] load_kw,
	input wire logic [4:0] limiter_in_control,
	input wire logic [15:0] remote_ref_value,
	output logic trip_relay,
	output logic alarm_relay,
	output logic indicator_relay,
	output logic actuator_shutdown,
	output logic select_digital_speed_path,
	output logic [15:0] remote_speed_ref,
	output logic [15:0] remote_baseload_ref
);
	// Configuration registers
	logic [31:0] ctrl; // Mode and polarity bits
	logic [NUM_COND-1:0] sd_en; // Route to shutdown
	logic [NUM_COND-1:0] alm_en; // Route to alarm
	logic [5:0] ind_en; // Indicator relay sources
	logic [15:0] analog_sensor1_tooth_count;
	logic [15:0] digital_sensor1_tooth_count;
	logic [15:0] analog_sensor1_freq_range;
	logic [15:0] rated_rpm;
	logic [7:0] pickup_pct; // Pickup-valid percentage
	limit_cfg_s fuel_demand_trip_level;
	limit_cfg_s overspeed_trip_level;
	limit_cfg_s load_trip_level;
	logic [7:0] torsional_trip_level; // Percent of full scale
	logic [7:0] torsional_full_scale; // Percent of rated rpm
	logic [7:0] torsion_delay_s;
	logic [15:0] speed_switch_on_level;
	logic [15:0] speed_switch_off_level;
	logic [7:0] pickup_fail_arm_delay;
	// Internal state
	ahb_phase_s dphase; // Pending data phase
	logic [1:0] run_sync, reset_sync; // Pin synchronisers
	logic reset_pin_prev; // Edge detect on clean level
	logic sw_reset_pulse; // Alarm reset written by software
	logic [15:0] engine_rpm;
	logic pickup_valid, pickup_seen, armed;
	logic [31:0] arm_cnt;
	logic speed_switch;
	logic [NUM_COND-1:0] cond_now; // Live conditions
	logic [NUM_COND-1:0] sd_latch, alm_latch;
	logic [3:0] first_sd; // 0 means none, else index+1
	logic freq_over_range;
	// Divider state
	typedef enum {DIV_LOAD, DIV_RUN} div_state_e;
	div_state_e div_state;
	logic [21:0] div_num; // Dividend, shifted out
	logic [15:0] div_den;
	logic [15:0] div_rem;
	logic [21:0] div_quo;
	logic [4:0] div_step;
	// Combinational helpers
	logic run_closed;
	logic reset_req;
	logic [3:0] over; // Fuel, speed, load above level; torsion at or above level
	logic [3:0] expired;
	logic [39:0] tors_lhs, tors_rhs;
	logic [15:0] sel_freq, sel_teeth;
	logic [16:0] rem_shift;

	assign run_closed = run_sync[1];
	assign reset_req = sw_reset_pulse | (reset_sync[1] & ~reset_pin_prev);

	// Two-stage synchronisers for the asynchronous pins
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			run_sync <= 2'b00;
			reset_sync <= 2'b00;
			reset_pin_prev <= 1'b0;
		end else if (clk_en) begin
			run_sync <= {run_sync[0], run_contact_pin};
			reset_sync <= {reset_sync[0], alarm_reset_pin};
			reset_pin_prev <= reset_sync[1]; // Reads only the second stage
		end
	end

	// Bus address phase capture; zero wait states, always OKAY
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			dphase <= '0;
			hreadyout <= 1'b1;
			hresp <= 1'b0;
		end else if (clk_en) begin
			hreadyout <= 1'b1;
			hresp <= 1'b0;
			if (hready) begin
				dphase.valid <= hsel & htrans[1];
				dphase.write <= hwrite;
				dphase.addr <= {haddr[7:2], 2'b00};
			end
		end
	end

	// Read data loaded at the address phase, so it stands in the data phase
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			hrdata <= 32'h0000_0000;
		end else if (clk_en && hready && hsel && htrans[1] && !hwrite) begin
			case ({haddr[7:2], 2'b00})
				OFS_CTRL: hrdata <= {ctrl[31:9], 1'b0, ctrl[7:0]}; // Reset bit reads 0
				OFS_SD_EN: hrdata <= 32'(sd_en);
				OFS_ALM_EN: hrdata <= 32'(alm_en);
				OFS_IND_EN: hrdata <= 32'(ind_en);
				OFS_TEETH: hrdata <= {digital_sensor1_tooth_count, analog_sensor1_tooth_count};
				OFS_FREQ_RANGE: hrdata <= 32'(analog_sensor1_freq_range);
				OFS_RATED: hrdata <= {8'h00, pickup_pct, rated_rpm};
				OFS_FUEL: hrdata <= 32'(fuel_demand_trip_level);
				OFS_SPEED: hrdata <= 32'(overspeed_trip_level);
				OFS_TORS: hrdata <= {8'h00, torsion_delay_s, torsional_full_scale,
					torsional_trip_level};
				OFS_LOAD: hrdata <= 32'(load_trip_level);
				OFS_SWITCH: hrdata <= {speed_switch_off_level, speed_switch_on_level};
				OFS_ARM: hrdata <= 32'(pickup_fail_arm_delay);
				OFS_STATUS: hrdata <= {12'h000, freq_over_range, speed_switch, pickup_valid,
					armed, 5'h00, cond_now};
				OFS_LATCH: hrdata <= {5'h00, alm_latch, 5'h00, sd_latch};
				OFS_FIRST: hrdata <= 32'(first_sd);
				OFS_RPM: hrdata <= 32'(engine_rpm);
				default: hrdata <= 32'h0000_0000; // Unmapped reads zero
			endcase
		end
	end

	// Register writes in the data phase; unmapped writes are dropped
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			ctrl <= 32'h0000_0000;
			sd_en <= '0;
			alm_en <= '0;
			ind_en <= '0;
			analog_sensor1_tooth_count <= 16'h0000;
			digital_sensor1_tooth_count <= 16'h0000;
			analog_sensor1_freq_range <= 16'hFFFF;
			rated_rpm <= 16'h0000;
			pickup_pct <= PICKUP_PCT_RESET;
			fuel_demand_trip_level <= '1;
			overspeed_trip_level <= '1;
			load_trip_level <= '1;
			torsional_trip_level <= PCT_FULL;
			torsional_full_scale <= TORSIONAL_FULL_SCALE_RESET;
			torsion_delay_s <= 8'h00;
			speed_switch_on_level <= 16'h0000;
			speed_switch_off_level <= 16'h0000;
			pickup_fail_arm_delay <= 8'h00;
			sw_reset_pulse <= 1'b0;
		end else if (clk_en) begin
			sw_reset_pulse <= 1'b0;
			if (dphase.valid && dphase.write) begin
				case (dphase.addr)
					OFS_CTRL: begin
						ctrl <= {23'h000000, 1'b0, hwdata[7:0]};
						sw_reset_pulse <= hwdata[CTRL_ALM_RESET]; // Self-clearing
					end
					OFS_SD_EN: sd_en <= hwdata[NUM_COND-1:0];
					OFS_ALM_EN: alm_en <= hwdata[NUM_COND-1:0];
					OFS_IND_EN: ind_en <= hwdata[5:0];
					OFS_TEETH: begin
						analog_sensor1_tooth_count <= hwdata[15:0];
						digital_sensor1_tooth_count <= hwdata[31:16];
					end
					OFS_FREQ_RANGE: analog_sensor1_freq_range <= hwdata[15:0];
					OFS_RATED: begin
						rated_rpm <= hwdata[15:0];
						pickup_pct <= hwdata[23:16];
					end
					OFS_FUEL: fuel_demand_trip_level <= hwdata[23:0];
					OFS_SPEED: overspeed_trip_level <= hwdata[23:0];
					OFS_TORS: begin
						torsional_trip_level <= hwdata[7:0];
						torsional_full_scale <= hwdata[15:8];
						torsion_delay_s <= hwdata[23:16];
					end
					OFS_LOAD: load_trip_level <= hwdata[23:0];
					OFS_SWITCH: begin
						speed_switch_on_level <= hwdata[15:0];
						speed_switch_off_level <= hwdata[31:16];
					end
					OFS_ARM: pickup_fail_arm_delay <= hwdata[7:0];
					default: ;
				endcase
			end
		end
	end

	// Speed path select and tooth count per path
	always_comb begin
		sel_freq = ctrl[CTRL_DIG_SEL] ? digital_freq_hz : analog_freq_hz;
		sel_teeth = ctrl[CTRL_DIG_SEL] ? digital_sensor1_tooth_count
			: analog_sensor1_tooth_count;
		rem_shift = {div_rem, div_num[21]};
	end

	// Restoring divider: rpm = freq * 60 / teeth, one quotient bit a cycle
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			div_state <= DIV_LOAD;
			div_num <= 22'h00_0000;
			div_den <= 16'h0000;
			div_rem <= 16'h0000;
			div_quo <= 22'h00_0000;
			div_step <= 5'h00;
			engine_rpm <= 16'h0000;
		end else if (clk_en) begin
			case (div_state)
				DIV_LOAD: begin
					div_num <= 22'(sel_freq) * 22'(SEC_PER_MIN);
					div_den <= sel_teeth;
					div_rem <= 16'h0000;
					div_quo <= 22'h00_0000;
					div_step <= 5'd22;
					// Zero teeth gives no meaningful speed
					if (sel_teeth == 16'h0000) begin
						engine_rpm <= 16'h0000;
					end else begin
						div_state <= DIV_RUN;
					end
				end
				DIV_RUN: begin
					div_num <= {div_num[20:0], 1'b0};
					if (rem_shift >= {1'b0, div_den}) begin
						div_rem <= 16'(rem_shift - {1'b0, div_den});
						div_quo <= {div_quo[20:0], 1'b1};
					end else begin
						div_rem <= rem_shift[15:0];
						div_quo <= {div_quo[20:0], 1'b0};
					end
					div_step <= div_step - 5'd1;
					if (div_step == 5'd1) begin
						// Saturate rather than wrap on huge results
						engine_rpm <= (div_quo[20:15] != 6'h00) ? 16'hFFFF
							: {div_quo[14:0], (rem_shift >= {1'b0, div_den})};
						div_state <= DIV_LOAD;
					end
				end
				default: div_state <= DIV_LOAD;
			endcase
		end
	end

	// Torsion compare: level*100*100 >= rated*scale%*setpt%
	always_comb begin
		tors_lhs = 40'(torsional_level) * 40'(PCT_FULL) * 40'(PCT_FULL);
		tors_rhs = 40'(rated_rpm) * 40'(torsional_full_scale) * 40'(torsional_trip_level);
		over[0] = fuel_demand_pct > fuel_demand_trip_level.level;
		over[1] = engine_rpm > overspeed_trip_level.level;
		over[2] = tors_lhs >= tors_rhs;
		over[3] = load_kw > load_trip_level.level;
	end

	// One delay timer per over-level check
	genvar gi;
	generate
		for (gi = 0; gi < 4; gi++) begin : g_timer
			logic [31:0] cnt; // Cycles spent over level; at or above it for torsion
			logic [7:0] dly;
			assign dly = (gi == 0) ? fuel_demand_trip_level.delay_s
				: (gi == 1) ? overspeed_trip_level.delay_s
				: (gi == 2) ? torsion_delay_s : load_trip_level.delay_s;
			assign expired[gi] = over[gi] &&
				(40'(cnt) >= 40'(dly) * 40'(CYCLES_PER_SECOND));
			// Drop back restarts the count from zero
			always_ff @(posedge hclk or negedge hresetn) begin
				if (!hresetn) begin
					cnt <= 32'h0000_0000;
				end else if (clk_en) begin
					if (!over[gi]) begin
						cnt <= 32'h0000_0000;
					end else if (cnt != 32'hFFFF_FFFF) begin
						cnt <= cnt + 32'd1;
					end
				end
			end
		end
	endgenerate

	// Pickup detection and arming latch
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			pickup_valid <= 1'b0;
			pickup_seen <= 1'b0;
			armed <= 1'b0;
			arm_cnt <= 32'h0000_0000;
		end else if (clk_en) begin
			pickup_valid <= (24'(engine_rpm) * 24'(PCT_FULL)) >=
				(24'(rated_rpm) * 24'(pickup_pct));
			if (!run_closed) begin
				// Normal stop must not trip sensor-loss faults
				pickup_seen <= 1'b0;
				armed <= 1'b0;
				arm_cnt <= 32'h0000_0000;
			end else begin
				if (pickup_valid) begin
					pickup_seen <= 1'b1;
				end
				if (pickup_seen && !armed) begin
					if (40'(arm_cnt) >= 40'(pickup_fail_arm_delay) * 40'(CYCLES_PER_SECOND)) begin
						armed <= 1'b1;
					end else begin
						arm_cnt <= arm_cnt + 32'd1;
					end
				end
			end
		end
	end

	// Speed switch with hysteresis; direction set by level order
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			speed_switch <= 1'b0;
		end else if (clk_en) begin
			if (speed_switch_on_level < speed_switch_off_level) begin
				// Underspeed style
				if (engine_rpm < speed_switch_on_level) begin
					speed_switch <= 1'b1;
				end else if (engine_rpm > speed_switch_off_level) begin
					speed_switch <= 1'b0;
				end
			end else begin
				// Overspeed style
				if (engine_rpm > speed_switch_on_level) begin
					speed_switch <= 1'b1;
				end else if (engine_rpm < speed_switch_off_level) begin
					speed_switch <= 1'b0;
				end
			end
		end
	end

	// Live fault conditions, registered once
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			cond_now <= '0;
			freq_over_range <= 1'b0;
		end else if (clk_en) begin
			cond_now[C_S1] <= armed & run_closed & sensor1_lost;
			cond_now[C_S2] <= armed & run_closed & sensor2_lost;
			cond_now[C_BOTH] <= armed & run_closed & sensor1_lost & sensor2_lost;
			cond_now[C_LOAD_LOOP] <= (load_loop_current < LOOP_LOW_LIMIT) ||
				(load_loop_current > LOOP_HIGH_LIMIT);
			cond_now[C_REM_LOOP] <= (remote_loop_current < LOOP_LOW_LIMIT) ||
				(remote_loop_current > LOOP_HIGH_LIMIT);
			cond_now[C_FUEL_LOOP] <= (fuel_limit_loop_current < LOOP_LOW_LIMIT) ||
				(fuel_limit_loop_current > LOOP_HIGH_LIMIT);
			cond_now[C_LINK] <= serial_link_error;
			cond_now[C_FUEL] <= expired[0];
			cond_now[C_SPEED] <= expired[1];
			cond_now[C_TORS] <= expired[2];
			cond_now[C_LOAD] <= expired[3];
			freq_over_range <= sel_freq > analog_sensor1_freq_range;
		end
	end

	// Latches: new events beat a reset in the same cycle
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			sd_latch <= '0;
			alm_latch <= '0;
		end else if (clk_en) begin
			for (int i = 0; i < NUM_COND; i++) begin
				if (cond_now[i] && sd_en[i]) begin
					sd_latch[i] <= 1'b1;
				end else if (reset_req && !cond_now[i]) begin
					sd_latch[i] <= 1'b0;
				end
				if (cond_now[i] && alm_en[i]) begin
					alm_latch[i] <= 1'b1;
				end else if (reset_req && !cond_now[i]) begin
					alm_latch[i] <= 1'b0;
				end
			end
		end
	end

	// First-out capture; lowest index wins a tie
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			first_sd <= 4'h0;
		end else if (clk_en) begin
			if (sd_latch == '0) begin
				first_sd <= 4'h0;
				for (int i = NUM_COND - 1; i >= 0; i--) begin
					if (cond_now[i] && sd_en[i]) begin
						first_sd <= 4'(i + 1);
					end
				end
			end
		end
	end

	// Relays, actuator and reference routing, all registered
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			trip_relay <= 1'b0;
			alarm_relay <= 1'b0;
			indicator_relay <= 1'b0;
			actuator_shutdown <= 1'b0;
			select_digital_speed_path <= 1'b0;
			remote_speed_ref <= 16'h0000;
			remote_baseload_ref <= 16'h0000;
		end else if (clk_en) begin
			trip_relay <= (|sd_latch) ~^ ctrl[CTRL_SD_POL];
			alarm_relay <= (|alm_latch) ~^ ctrl[CTRL_ALM_POL];
			indicator_relay <= |(limiter_in_control & ind_en[4:0])
				| (speed_switch & ind_en[5]);
			actuator_shutdown <= (|sd_latch) & ctrl[CTRL_ACT_OFF];
			select_digital_speed_path <= ctrl[CTRL_DIG_SEL];
			if (ctrl[CTRL_REM_SPEED]) begin
				remote_speed_ref <= remote_ref_value;
			end else begin
				remote_baseload_ref <= remote_ref_value;
			end
		end
	end
endmodule
`default_nettype wire

// >>> inc/trip_monitor_pkg.sv
/*
 * Shared constants and carrier types for the engine trip monitor.
 * Assumes a 10 MHz bus clock and a 32-bit AHB-Lite register bus.
 */
`default_nettype none
package trip_monitor_pkg;
	// Register byte offsets
	localparam logic [7:0] OFS_CTRL = 8'h00;
	localparam logic [7:0] OFS_SD_EN = 8'h04;
	localparam logic [7:0] OFS_ALM_EN = 8'h08;
	localparam logic [7:0] OFS_IND_EN = 8'h0C;
	localparam logic [7:0] OFS_TEETH = 8'h10;
	localparam logic [7:0] OFS_FREQ_RANGE = 8'h14;
	localparam logic [7:0] OFS_RATED = 8'h18;
	localparam logic [7:0] OFS_FUEL = 8'h1C;
	localparam logic [7:0] OFS_SPEED = 8'h20;
	localparam logic [7:0] OFS_TORS = 8'h24;
	localparam logic [7:0] OFS_LOAD = 8'h28;
	localparam logic [7:0] OFS_SWITCH = 8'h2C;
	localparam logic [7:0] OFS_ARM = 8'h30;
	localparam logic [7:0] OFS_STATUS = 8'h34;
	localparam logic [7:0] OFS_LATCH = 8'h38;
	localparam logic [7:0] OFS_FIRST = 8'h3C;
	localparam logic [7:0] OFS_RPM = 8'h40;
	// Control register fields
	localparam int CTRL_DIG_SEL = 0;
	localparam int CTRL_REM_SPEED = 1;
	localparam int CTRL_SD_POL = 2;
	localparam int CTRL_ALM_POL = 3;
	localparam int CTRL_ACT_OFF = 4;
	localparam int CTRL_ALM_RESET = 8;
	// Condition indices
	localparam int NUM_COND = 11;
	localparam int C_S1 = 0;
	localparam int C_S2 = 1;
	localparam int C_BOTH = 2;
	localparam int C_LOAD_LOOP = 3;
	localparam int C_REM_LOOP = 4;
	localparam int C_FUEL_LOOP = 5;
	localparam int C_LINK = 6;
	localparam int C_FUEL = 7;
	localparam int C_SPEED = 8;
	localparam int C_TORS = 9;
	localparam int C_LOAD = 10;
	// Loop current window, units of 10 uA
	localparam logic [11:0] LOOP_LOW_LIMIT = 12'h0C8;
	localparam logic [11:0] LOOP_HIGH_LIMIT = 12'h834;
	// Reset values
	localparam logic [7:0] PICKUP_PCT_RESET = 8'h05;
	localparam logic [7:0] TORSIONAL_FULL_SCALE_RESET = 8'h01;
	// Scale factors
	localparam logic [5:0] SEC_PER_MIN = 6'h3C;
	localparam logic [7:0] PCT_FULL = 8'h64;
	// Timing
	localparam longint ONE_SECOND_NS = 1000000000;
	localparam longint CLK_PERIOD_NS = 100;
	localparam int unsigned CYCLES_PER_SEC = int'(ONE_SECOND_NS / CLK_PERIOD_NS);
	// Captured AHB address phase
	typedef struct packed {
		logic valid;
		logic write;
		logic [7:0] addr;
	} ahb_phase_s;
	// Level plus delay in seconds
	typedef struct packed {
		logic [7:0] delay_s;
		logic [15:0] level;
	} limit_cfg_s;
endpackage
`default_nettype wire

// >>> tb/engine_plant_model.sv
/*
 * Far-side model: loop transmitters and the serial link partner.
 * Assumes the bench commands faults in step with hclk.
 */
`timescale 1ns/1ps
`default_nettype none
module engine_plant_model (
	input wire logic hclk,
	input wire logic link_down,
	input wire logic [11:0] load_ma,
	input wire logic [11:0] rem_ma,
	output logic serial_link_error,
	output logic [11:0] load_loop_current,
	output logic [11:0] remote_loop_current,
	output logic [11:0] fuel_limit_loop_current
);
	// Transmitters refresh once a clock, like a sampled converter
	always_ff @(posedge hclk) begin
		serial_link_error <= link_down;
		load_loop_current <= load_ma;
		remote_loop_current <= rem_ma;
		fuel_limit_loop_current <= 12'h3E8; // Healthy 10 mA
	end
endmodule
`default_nettype wire

// >>> tb/engine_fault_trip_monitor_assertions.sv
/*
 * Port checker for the trip monitor, bound below.
 * Assumes one slave, so hready is the slave's own hreadyout.
 */
`timescale 1ns/1ps
`default_nettype none
module engine_fault_trip_monitor_assertions
	import trip_monitor_pkg::*;
(
	input wire logic hclk,
	input wire logic hresetn,
	input wire logic hsel,
	input wire logic [31:0] haddr,
	input wire logic [1:0] htrans,
	input wire logic hwrite,
	input wire logic [31:0] hwdata,
	input wire logic hready,
	input wire logic serial_link_error,
	input wire logic [11:0] load_loop_current,
	input wire logic [11:0] remote_loop_current,
	input wire logic [4:0] limiter_in_control,
	input wire logic [15:0] remote_ref_value,
	input wire logic trip_relay,
	input wire logic indicator_relay,
	input wire logic actuator_shutdown,
	input wire logic select_digital_speed_path,
	input wire logic [15:0] remote_speed_ref,
	input wire logic [15:0] remote_baseload_ref
);
	default clocking @(posedge hclk); endclocking
	default disable iff (!hresetn);
	logic wr_q; // Write in data phase
	logic [7:0] a_q;
	logic [31:0] ctrl_q, sd_q, ind_q; // Config shadows
	// Shadows land at the data-phase edge, as the device's own do
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			wr_q <= 1'b0;
			a_q <= 8'h00;
			ctrl_q <= 32'h0000_0000;
			sd_q <= 32'h0000_0000;
			ind_q <= 32'h0000_0000;
		end else if (hready) begin
			wr_q <= hsel && htrans[1] && hwrite;
			a_q <= haddr[7:0];
			if (wr_q && a_q == OFS_CTRL) ctrl_q <= hwdata;
			if (wr_q && a_q == OFS_SD_EN) sd_q <= hwdata;
			if (wr_q && a_q == OFS_IND_EN) ind_q <= hwdata;
		end
	end
	property p_path_sel;
		$stable(ctrl_q)[*3] |-> select_digital_speed_path == ctrl_q[CTRL_DIG_SEL];
	endproperty
	a_path_sel: assert property (p_path_sel) else $error("path select wrong");
	property p_ref_route;
		$stable(ctrl_q)[*3] |=> ($past(ctrl_q[CTRL_REM_SPEED]) ? remote_speed_ref :
			remote_baseload_ref) == $past(remote_ref_value);
	endproperty
	a_ref_route: assert property (p_ref_route) else $error("remote ref misrouted");
	property p_act_off;
		$stable(ctrl_q)[*3] && !ctrl_q[CTRL_ACT_OFF] |-> !actuator_shutdown;
	endproperty
	a_act_off: assert property (p_act_off) else $error("actuator cut while off");
	property p_trip_pol;
		$stable(ctrl_q)[*3] && actuator_shutdown |-> trip_relay == ctrl_q[CTRL_SD_POL];
	endproperty
	a_trip_pol: assert property (p_trip_pol) else $error("trip relay polarity");
	property p_ind;
		$stable(ind_q)[*3] && !ind_q[5] |=>
			indicator_relay == |($past(limiter_in_control) & $past(ind_q[4:0]));
	endproperty
	a_ind: assert property (p_ind) else $error("indicator relay wrong");
	property p_link;
		serial_link_error && sd_q[C_LINK] && ctrl_q[CTRL_ACT_OFF] |-> ##[1:3] actuator_shutdown;
	endproperty
	a_link: assert property (p_link) else $error("link fault no trip");
	property p_loop_low;
		load_loop_current < LOOP_LOW_LIMIT && sd_q[C_LOAD_LOOP] && ctrl_q[CTRL_ACT_OFF]
			|-> ##[1:3] actuator_shutdown;
	endproperty
	a_loop_low: assert property (p_loop_low) else $error("low loop no trip");
	property p_loop_high;
		remote_loop_current > LOOP_HIGH_LIMIT && sd_q[C_REM_LOOP] && ctrl_q[CTRL_ACT_OFF]
			|-> ##[1:3] actuator_shutdown;
	endproperty
	a_loop_high: assert property (p_loop_high) else $error("high loop no trip");
	c_trip: cover property (actuator_shutdown);
	c_ind: cover property (indicator_relay);
	c_relay: cover property (!trip_relay);
endmodule
bind engine_fault_trip_monitor engine_fault_trip_monitor_assertions u_chk (.hclk, .hresetn,
	.hsel, .haddr, .htrans, .hwrite, .hwdata, .hready, .serial_link_error, .load_loop_current,
	.remote_loop_current, .limiter_in_control, .remote_ref_value, .trip_relay,
	.indicator_relay, .actuator_shutdown, .select_digital_speed_path, .remote_speed_ref,
	.remote_baseload_ref);
`default_nettype wire

// >>> tb/engine_fault_trip_monitor_test.sv
/*
 * Self-checking bench for the trip monitor: register bus, relays, timers.
 * Assumes a zero-wait-state slave and a 20-cycle second.
 */
`timescale 1ns/1ps
`default_nettype none
module engine_fault_trip_monitor_test import trip_monitor_pkg::*;;
	logic hclk = 0, hresetn = 0, hsel = 0, hwrite = 0, link_down = 0;
	logic run_pin = 0, arst_pin = 0, s1l = 0, s2l = 0, hreadyout, hresp, dig_sel, slink;
	logic trip_relay, alarm_relay, indicator_relay, actuator_shutdown;
	logic [1:0] htrans = 0, go = 0; // Which result is on show
	logic [31:0] haddr = 0, hwdata = 0, hrdata, exp_v, got, q[$];
	logic [15:0] freq = 0, fuel = 0, tors = 0, kw = 0, rref = 0, rs, rb;
	logic [11:0] load_ma = 12'h3E8, rem_ma = 12'h3E8, l1, l2, l3;
	logic [4:0] lim = 0;
	int errors = 0, checked = 0, seed;
	initial forever #50 hclk = ~hclk;
	engine_fault_trip_monitor #(.CYCLES_PER_SECOND(20)) u_dut (.hclk, .hresetn,
		.clk_en(1'b1), .hsel, .haddr, .htrans, .hwrite, .hsize(3'h2), .hwdata,
		.hready(hreadyout), .hreadyout, .hresp, .hrdata, .run_contact_pin(run_pin),
		.alarm_reset_pin(arst_pin), .sensor1_lost(s1l), .sensor2_lost(s2l),
		.analog_freq_hz(freq), .digital_freq_hz(freq), .load_loop_current(l1),
		.remote_loop_current(l2), .fuel_limit_loop_current(l3), .serial_link_error(slink),
		.fuel_demand_pct(fuel), .torsional_level(tors), .load_kw(kw),
		.limiter_in_control(lim), .remote_ref_value(rref), .trip_relay, .alarm_relay,
		.indicator_relay, .actuator_shutdown, .select_digital_speed_path(dig_sel),
		.remote_speed_ref(rs), .remote_baseload_ref(rb));
	engine_plant_model u_plant (.hclk, .link_down, .load_ma, .rem_ma,
		.serial_link_error(slink), .load_loop_current(l1), .remote_loop_current(l2),
		.fuel_limit_loop_current(l3));
	task automatic finish_test;
		$display("checks %0d errors %0d", checked, errors);
		if (errors == 0 && checked > 0)
			$display("TEST PASSED");
		else
			$display("TEST FAILED");
		$finish;
	endtask
	// Result watcher: takes the oldest note when a result stands
	always @(posedge hclk) begin
		if (go != 2'h0) begin
			got = (go == 2'h1) ? hrdata : {27'h0, hresp, trip_relay, alarm_relay,
				indicator_relay, actuator_shutdown};
			exp_v = q.pop_front();
			checked++;
			if (got !== exp_v) begin
				errors++;
				$display("ERROR %0t got %h expected %h", $time, got, exp_v);
			end
		end
	end
	// Bounded wait for hready; a hang ends the run
	task automatic edge_ready;
		int n = 0;
		@(posedge hclk);
		while (hreadyout !== 1'b1) begin
			if (++n > 50) begin
				errors++;
				$display("ERROR %0t bus hang", $time);
				finish_test();
			end
			@(posedge hclk);
		end
	endtask
	task automatic bus(input logic w, input logic [7:0] a, input logic [31:0] d);
		hsel <= 1'b1;
		htrans <= 2'h2;
		hwrite <= w;
		haddr <= {24'h0, a};
		edge_ready();
		hsel <= 1'b0;
		htrans <= 2'h0;
		hwdata <= d;
		go <= w ? 2'h0 : 2'h1;
		edge_ready();
		go <= 2'h0;
	endtask
	task automatic wr(input logic [7:0] a, input logic [31:0] d);
		bus(1'b1, a, d);
	endtask
	task automatic rd(input logic [7:0] a, input logic [31:0] e);
		q.push_back(e);
		bus(1'b0, a, 32'h0);
	endtask
	// Relay snapshot: trip, alarm, indicator, actuator
	task automatic out(input logic [3:0] e);
		q.push_back({28'h0, e});
		go <= 2'h2;
		@(posedge hclk);
		go <= 2'h0;
	endtask
	// Remote reference wanders at random on idle clocks, from the seeded thread
	task automatic idle(input int n);
		repeat (n) begin
			@(posedge hclk);
			rref <= 16'($urandom);
		end
	endtask
	initial begin
		seed = $urandom(32'h0000_03a3);
		idle(6);
		hresetn <= 1'b1;
		@(posedge hclk);
		out(4'hC);
		rd(OFS_FUEL, 32'h00FF_FFFF);
		wr(8'h50, 32'hFFFF_FFFF);
		rd(8'h50, 32'h0);
		wr(OFS_CTRL, 32'h3);
		idle(5);
		wr(OFS_CTRL, 32'h0000_0101);
		rd(OFS_CTRL, 32'h1);
		$display("reset and map done");
		for (int i = 0; i < 5; i++) begin
			wr(OFS_IND_EN, 32'(1) << i);
			lim <= ~(5'h1 << i);
			idle(3);
			out(4'hC);
			lim <= 5'h1 << i;
			idle(3);
			out(4'hE);
		end
		lim <= 5'h0;
		// Switch on below 1000 rpm, off above 2000 rpm
		wr(OFS_TEETH, 32'h003C_003C);
		wr(OFS_SWITCH, 32'h07D0_03E8);
		wr(OFS_IND_EN, 32'h20);
		freq <= 16'h01F4;
		idle(60);
		out(4'hE);
		freq <= 16'h05DC;
		idle(60);
		out(4'hE);
		freq <= 16'h09C4;
		idle(60);
		out(4'hC);
		freq <= 16'h05DC;
		idle(60);
		out(4'hC);
		wr(OFS_IND_EN, 32'h0);
		freq <= 16'h01F4;
		idle(60);
		out(4'hC);
		$display("indicator done");
		wr(OFS_SD_EN, 32'h40);
		wr(OFS_CTRL, 32'h10);
		link_down <= 1'b1;
		idle(6);
		out(4'h5);
		rd(OFS_FIRST, 32'h7);
		wr(OFS_CTRL, 32'h0000_0110);
		idle(2);
		rd(OFS_LATCH, 32'h40);
		link_down <= 1'b0;
		idle(4);
		wr(OFS_CTRL, 32'h0000_0110);
		idle(2);
		rd(OFS_LATCH, 32'h0);
		rd(OFS_FIRST, 32'h0);
		out(4'hC);
		$display("link fault done");
		wr(OFS_ALM_EN, 32'h8);
		wr(OFS_SD_EN, 32'h18);
		wr(OFS_CTRL, 32'h14);
		load_ma <= 12'h0C7;
		idle(6);
		rem_ma <= 12'h835;
		idle(6);
		out(4'h9);
		rd(OFS_FIRST, 32'h4);
		rd(OFS_LATCH, 32'h0008_0018);
		load_ma <= LOOP_LOW_LIMIT;
		rem_ma <= LOOP_HIGH_LIMIT;
		idle(4);
		wr(OFS_CTRL, 32'h0000_0114);
		idle(2);
		rd(OFS_LATCH, 32'h0);
		$display("loop fault done");
		// Fuel over 100 % for 2 s, broken once by a return to level
		wr(OFS_SD_EN, 32'h80);
		wr(OFS_FUEL, 32'h0002_0064);
		fuel <= 16'h0065;
		idle(30);
		fuel <= 16'h0064;
		@(posedge hclk);
		fuel <= 16'h0065;
		idle(30);
		rd(OFS_LATCH, 32'h0);
		idle(20);
		rd(OFS_LATCH, 32'h80);
		// 1200 rpm rated, 1 % scale, 50 %: trips at 6 rpm
		wr(OFS_RATED, 32'h0005_04B0);
		wr(OFS_TORS, 32'h0000_0132);
		wr(OFS_SD_EN, 32'h280);
		tors <= 16'h0005;
		idle(6);
		rd(OFS_LATCH, 32'h80);
		tors <= 16'h0006;
		idle(6);
		rd(OFS_LATCH, 32'h280);
		$display("timer and torsion done");
		// Sensor loss arms only after pickup and 1 s of run
		fuel <= 16'h0000;
		tors <= 16'h0000;
		s1l <= 1'b1;
		s2l <= 1'b1;
		wr(OFS_ARM, 32'h1);
		wr(OFS_SD_EN, 32'h7);
		wr(OFS_CTRL, 32'h0000_0114);
		idle(2);
		rd(OFS_LATCH, 32'h0);
		run_pin <= 1'b1;
		idle(10);
		rd(OFS_LATCH, 32'h0);
		idle(30);
		rd(OFS_LATCH, 32'h7);
		rd(OFS_FIRST, 32'h1);
		// Stop first, then reset through the pin
		run_pin <= 1'b0;
		idle(4);
		arst_pin <= 1'b1;
		idle(6);
		arst_pin <= 1'b0;
		rd(OFS_LATCH, 32'h0);
		$display("sensor loss done");
		finish_test();
	end
endmodule
`default_nettype wire
